/* dv/sahu_checker.sv */
`timescale 1ns/1ps
module sahu_checker (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RST_B,
  input  wire logic [3:0]            I_AVS_ADDRESS,
  input  wire logic                  I_AVS_WRITE,
  input  wire logic [31:0]           I_AVS_WRITEDATA,
  input  wire logic                  O_AVS_WAITREQUEST,
  input  wire sahu_pkg::sahu_req_t   I_REQ,
  input  wire sahu_pkg::sahu_dec_t   I_DEC,
  input  wire logic                  I_NMI,
  input  wire logic                  I_OUTPUT_FLOAT_REQUEST,
  input  wire logic                  I_MASKABLE_INTERRUPT_REQUEST,
  input  wire logic [31:0]           O_PHYS_ADDR,
  input  wire logic                  O_PHYS_VALID,
  input  wire logic                  O_BUS_ENABLE,
  input  wire logic                  O_BUS_LOCK,
  input  wire logic                  O_OPSZ32,
  input  wire sahu_pkg::sahu_fault_t O_FAULT,
  input  wire logic                  O_HALTED
);
  import sahu_pkg::*;
  logic        pe;
  logic        ie;
  logic [16:0] end_off;
  logic [19:0] real_sum;
  logic        plain;
  // mirror of the mode and interrupt-enable bits, taken at every accepted write to OFF_CTRL whatever the byte enables
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pe <= 1'b0;
      ie <= 1'b0;
    end else if (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == OFF_CTRL) begin
      pe <= I_AVS_WRITEDATA[CTRL_PE];
      ie <= I_AVS_WRITEDATA[CTRL_IF];
    end
  end
  // last byte of the access and the shifted segment sum; stack and decode traffic excluded
  assign end_off  = {1'b0, I_REQ.offset[15:0]} + {14'h0, I_REQ.size_m1};
  assign real_sum = {I_REQ.segment, 4'h0} + {4'h0, I_REQ.offset[15:0]};
  assign plain    = I_REQ.valid && !I_REQ.stack && !I_DEC.valid && !O_HALTED && !pe;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);
  a_real_addr: assert property (
    plain && !end_off[16] |=> O_PHYS_VALID && O_PHYS_ADDR[19:0] == $past(real_sum))
    else $error("real mode address wrong");
  a_seg_overrun: assert property (
    plain && end_off[16] |=> O_FAULT.valid && O_FAULT.vector == FAULT_GP && !O_PHYS_VALID)
    else $error("segment overrun not faulted");
  a_no_rsvd_vec: assert property (
    O_FAULT.valid && !pe |-> !(O_FAULT.vector inside {8'h0A, 8'h0B, 8'h0E}))
    else $error("vector not allowed in real mode");
  a_lock_refused: assert property (
    I_DEC.valid && I_DEC.lock_prefix && (I_DEC.lkcls == SAHU_LK_OTHER || I_DEC.rep_string) && !O_HALTED
    |=> O_FAULT.valid && O_FAULT.vector == FAULT_UD)
    else $error("illegal lock not faulted");
  a_lock_held: assert property (
    I_DEC.valid && I_DEC.lock_prefix && I_DEC.mem_dest && !I_DEC.rep_string
    && I_DEC.lkcls != SAHU_LK_OTHER && !O_HALTED |-> ##[1:2] O_BUS_LOCK)
    else $error("legal lock did not hold the bus");
  a_halt_entry: assert property (
    I_DEC.valid && I_DEC.halt_instruction && !O_HALTED && !I_NMI && !I_OUTPUT_FLOAT_REQUEST
    && !(I_MASKABLE_INTERRUPT_REQUEST && ie) |-> ##2 O_HALTED)
    else $error("halt not entered");
  a_halt_quiet: assert property ($rose(O_HALTED) |-> !O_BUS_ENABLE)
    else $error("bus enabled while halted");
  a_halt_wake: assert property (
    O_HALTED && (I_NMI || I_OUTPUT_FLOAT_REQUEST) |-> ##[1:2] !O_HALTED)
    else $error("halt not left on wake event");
  a_real_opsz: assert property (
    I_DEC.valid && !I_DEC.size_ovr && !pe |=> !O_OPSZ32)
    else $error("wide operands without prefix");
  c_halt: cover property ($rose(O_HALTED));
  c_lock: cover property ($rose(O_BUS_LOCK));
  c_gp: cover property (O_FAULT.valid && O_FAULT.vector == FAULT_GP);
endmodule : sahu_checker

bind sahu_top sahu_checker u_chk (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_REQ(I_REQ), .I_DEC(I_DEC), .I_NMI(I_NMI),
  .I_OUTPUT_FLOAT_REQUEST(I_OUTPUT_FLOAT_REQUEST), .I_MASKABLE_INTERRUPT_REQUEST(I_MASKABLE_INTERRUPT_REQUEST),
  .O_PHYS_ADDR(O_PHYS_ADDR), .O_PHYS_VALID(O_PHYS_VALID), .O_BUS_ENABLE(O_BUS_ENABLE), .O_BUS_LOCK(O_BUS_LOCK),
  .O_OPSZ32(O_OPSZ32), .O_FAULT(O_FAULT), .O_HALTED(O_HALTED), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));

/* dv/test_segment_address_and_halt_unit.sv */
`timescale 1ns/1ps
module test_segment_address_and_halt_unit;
  import sahu_pkg::*;
  logic        clk, rst_b, av_rd, av_wr, av_wait, nmi, output_float_request, maskable_interrupt_request, int_v, phys_v, bus_en, bus_lk, opsz, halted, shut;
  logic [3:0]  av_addr;
  logic [7:0]  int_vec;
  logic [15:0] sp, sav_cs;
  logic [19:0] vaddr;
  logic [31:0] av_wd, av_rdata, paged, nip, phys, sav_ip, q;
  sahu_req_t   req;
  sahu_dec_t   dec;
  sahu_fault_t flt_o;
  int          mismatches;
  int          n_tests;
  sahu_top dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
    .I_AVS_WRITEDATA(av_wd), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait),
    .I_REQ(req), .I_DEC(dec), .I_PAGED_ADDR(paged), .I_NMI(nmi), .I_OUTPUT_FLOAT_REQUEST(output_float_request),
    .I_MASKABLE_INTERRUPT_REQUEST(maskable_interrupt_request), .I_INT_VALID(int_v), .I_INT_VECTOR(int_vec), .I_STACK_POINTER(sp),
    .I_NEXT_INSTRUCTION_POINTER(nip), .O_PHYS_ADDR(phys), .O_PHYS_VALID(phys_v), .O_BUS_ENABLE(bus_en),
    .O_BUS_LOCK(bus_lk), .O_OPSZ32(opsz), .O_FAULT(flt_o), .O_VECTOR_ADDR(vaddr), .O_HALTED(halted),
    .O_SHUTDOWN(shut), .O_SAVED_INSTRUCTION_POINTER(sav_ip), .O_SAVED_CODE_SEGMENT(sav_cs));
  // free-running core clock, 100 ns period
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // one bus access, entered just after a rising edge; request held until the edge that sees waitrequest low,
  // read data taken at that edge, then one idle edge so the next call never re-raises in the same step
  task automatic acc(input logic rd, input logic [3:0] a, input logic [31:0] d);
    av_addr <= a;
    av_rd <= rd;
    av_wr <= !rd;
    av_wd <= d;
    do begin
      @(posedge clk);
    end while (av_wait);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask : acc
  // one address request; a nonzero fault vector means no address is expected
  task automatic areq(input logic f, input logic [15:0] s, input logic [31:0] o, input logic [2:0] z,
                      input logic [31:0] ea, input logic [7:0] ev);
    req <= '{1'b1, f, 1'b0, s, o, z};
    @(posedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
    chk(32'(phys_v), 32'(ev == 8'h00));
    if (ev == 8'h00) chk(phys, ea);
    chk(32'({flt_o.valid, flt_o.vector}), {23'h0, ev != 8'h00, ev});
    @(posedge clk);
  endtask : areq
  // privilege fields and descriptor entry address for one selector and access byte
  task automatic lvl(input logic [15:0] s, input logic [7:0] a);
    logic [1:0] e;
    e = (s[1:0] > a[6:5]) ? s[1:0] : a[6:5];
    acc(1'b0, OFF_SELECTOR, 32'(s));
    acc(1'b0, OFF_ACCESS, 32'(a));
    acc(1'b1, OFF_LEVELS, 32'h0);
    chk(q, {24'h0, e, s[1:0], a[6:5], s[1:0]});
    acc(1'b1, OFF_DTADDR, 32'h0);
    chk(q, 32'h0000_1000 + {16'h0, s[15:3], 3'h0});
  endtask : lvl
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {clk, rst_b, av_rd, av_wr, nmi, output_float_request, maskable_interrupt_request, int_v} = '0;
    {av_addr, av_wd, int_vec, sp, paged, nip} = '0;
    req = '0;
    dec = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(sav_ip, RST_IP);
    chk(32'(sav_cs), 32'(RST_CS));
    acc(1'b1, OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, OFF_IDTLIM, 32'h0);
    chk(q, 32'(IDTLIM_RST));
    // protected addressing, paging and privilege levels
    acc(1'b0, OFF_CTRL, 32'h1);
    acc(1'b0, OFF_SEGBASE, 32'h0123_4000);
    areq(1'b0, 16'h0, 32'h00FF_F010, 3'h0, 32'h0023_3010, 8'h00);
    acc(1'b0, OFF_CTRL, 32'h3);
    paged <= 32'hABCD_E123;
    areq(1'b0, 16'h0, 32'h0000_0010, 3'h0, 32'h00CD_E123, 8'h00);
    acc(1'b0, OFF_DTBASE, 32'h0000_1000);
    lvl(16'h0011, 8'hC0);
    lvl(16'hFFFB, 8'hA0);
    // every lock class at level 3, then a locked repeated string
    for (int k = 0; k < 6; k++) begin
      dec <= '{1'b1, 1'b1, 1'b1, k == 5, 1'b0, 1'b0, sahu_lkcls_t'(k == 5 ? 3 : k)};
      @(posedge clk);
      dec <= '0;
      @(negedge clk);
      chk(32'({flt_o.valid, flt_o.vector}), (k == 0 || k == 5) ? 32'h0000_0106 : 32'h0);
      @(posedge clk);
      @(negedge clk);
      chk(32'(bus_lk), 32'(k != 0 && k != 5));
      @(posedge clk);
      acc(1'b0, OFF_CMD, 32'h2);
    end
    // reset in mid-run returns to real mode
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    acc(1'b1, OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, OFF_CTRL, 32'h2);
    areq(1'b0, 16'h1234, 32'h0000_0010, 3'h0, 32'h0001_2350, 8'h00);
    areq(1'b1, 16'hFFFF, 32'h0000_FFFE, 3'h1, 32'h0000_FFEE, 8'h00);
    areq(1'b0, 16'h0100, 32'h0000_FFFF, 3'h1, 32'h0, FAULT_GP);
    areq(1'b1, 16'h0100, 32'h0000_FFFD, 3'h3, 32'h0, FAULT_GP);
    for (int k = 0; k < 2; k++) begin
      dec <= '{1'b1, 1'b0, 1'b0, 1'b0, k == 1, 1'b0, SAHU_LK_OTHER};
      @(posedge clk);
      dec <= '0;
      @(negedge clk);
      chk(32'(opsz), 32'(k));
      @(posedge clk);
    end
    int_vec <= 8'hFF;
    int_v <= 1'b1;
    @(posedge clk);
    int_v <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({12'h0, vaddr}, 32'h0000_03FC);
    chk(32'(shut), 32'h0);
    // halt, with a masked request pending, left by nmi, float, then enabled request
    maskable_interrupt_request <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      dec <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, SAHU_LK_OTHER};
      nip <= 32'h0000_1230 + 32'(k);
      @(posedge clk);
      dec <= '0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'({halted, bus_en}), 32'h2);
      @(posedge clk);
      if (k == 2) acc(1'b0, OFF_CTRL, 32'h4);
      else {nmi, output_float_request} <= (k == 0) ? 2'b10 : 2'b01;
      repeat (3) @(posedge clk);
      {nmi, output_float_request} <= 2'b00;
      @(negedge clk);
      chk(32'(halted), 32'h0);
      chk(sav_ip, 32'h0000_1230 + 32'(k));
    end
    // shutdown on a vector past the table limit, then the nmi exit conditions
    @(posedge clk);
    maskable_interrupt_request <= 1'b0;
    acc(1'b0, OFF_IDTLIM, 32'h7);
    int_vec <= VEC_NMI;
    int_v <= 1'b1;
    @(posedge clk);
    int_v <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(shut), 32'h1);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      acc(1'b0, OFF_IDTLIM, (k == 0) ? 32'h7 : 32'h0000_000F);
      sp <= (k == 1) ? 16'h0005 : 16'h0006;
      nmi <= 1'b1;
      repeat (3) @(posedge clk);
      nmi <= 1'b0;
      @(negedge clk);
      chk(32'(shut), 32'(k != 2));
    end
    @(posedge clk);
    sp <= 16'h0001;
    req <= '{1'b1, 1'b0, 1'b1, 16'h0, 32'h0, 3'h1};
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(shut), 32'h1);
    report_and_stop();
  end
endmodule : test_segment_address_and_halt_unit

/* hw/sahu_pkg.sv */
package sahu_pkg;
  // register word offsets on the avalon slave
  localparam logic [3:0]  OFF_CTRL     = 4'h0;  // bit0 protected mode, bit1 paging, bit2 interrupt enable
  localparam logic [3:0]  OFF_STATUS   = 4'h1;  // mode / halt / shutdown / operand size / lock bits
  localparam logic [3:0]  OFF_IDTLIM   = 4'h2;  // interrupt table limit, 16 bits
  localparam logic [3:0]  OFF_SEGBASE  = 4'h3;  // protected base loaded from descriptor
  localparam logic [3:0]  OFF_ACCESS   = 4'h4;  // descriptor access byte
  localparam logic [3:0]  OFF_SELECTOR = 4'h5;  // current code selector
  localparam logic [3:0]  OFF_LEVELS   = 4'h6;  // privilege levels, read only
  localparam logic [3:0]  OFF_DTBASE   = 4'h7;  // descriptor table linear base
  localparam logic [3:0]  OFF_DTADDR   = 4'h8;  // computed descriptor entry address, read only
  localparam logic [3:0]  OFF_CMD      = 4'h9;  // write 1s: bit0 halt_instruction, bit1 release lock
  localparam int          CTRL_PE      = 0;
  localparam int          CTRL_PG      = 1;
  localparam int          CTRL_IF      = 2;
  localparam int          ST_HALT      = 0;
  localparam int          ST_SHUT      = 1;
  localparam int          ST_PE        = 2;
  localparam int          ST_OPSZ32    = 3;
  localparam int          ST_LOCKED    = 4;
  localparam int          SEG_SHIFT    = 4;      // real mode segment shift
  localparam logic [15:0] SEG_LAST     = 16'hFFFF; // 64-Kb segment, last offset
  localparam logic [19:0] VEC_TOP      = 20'h0_03FF;
  localparam logic [15:0] NMI_LIM_MIN  = 16'h000F;
  localparam logic [15:0] NMI_SP_MIN   = 16'h0005;
  localparam logic [7:0]  FAULT_UD     = 8'h06;
  localparam logic [7:0]  FAULT_DF     = 8'h08;
  localparam logic [7:0]  FAULT_GP     = 8'h0D;
  localparam logic [7:0]  VEC_NMI      = 8'h02;
  localparam logic [15:0] IDTLIM_RST   = 16'h03FF;
  localparam int          ENTRY_SHIFT  = 3;      // 8-byte descriptor entries
  localparam logic [15:0] RST_CS       = 16'hF000;
  localparam logic [31:0] RST_IP       = 32'h0000_FFF0;

  // lock legality classes of the decoded instruction
  typedef enum logic [2:0] {
    SAHU_LK_OTHER, SAHU_LK_BITTEST, SAHU_LK_XCHG, SAHU_LK_ALU, SAHU_LK_UNARY
  } sahu_lkcls_t;

  // one address request from the execution unit
  typedef struct packed {
    logic        valid;
    logic        fetch;     // instruction fetch rather than data
    logic        stack;     // stack push/call/int reference
    logic [15:0] segment;
    logic [31:0] offset;
    logic [2:0]  size_m1;   // operand bytes minus one
  } sahu_req_t;

  // decoded instruction attributes
  typedef struct packed {
    logic        valid;
    logic        lock_prefix;
    logic        mem_dest;
    logic        rep_string;
    logic        size_ovr;
    logic        halt_instruction;
    sahu_lkcls_t lkcls;
  } sahu_dec_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  vector;
  } sahu_fault_t;
endpackage : sahu_pkg

/* hw/sahu_top.sv */
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module sahu_top (
  input  wire logic                I_CLOCK,
  input  wire logic                I_RST_B,
  input  wire logic [3:0]          I_AVS_ADDRESS,
  input  wire logic                I_AVS_READ,
  input  wire logic                I_AVS_WRITE,
  input  wire logic [31:0]         I_AVS_WRITEDATA,
  input  wire logic [3:0]          I_AVS_BYTEENABLE,
  output logic      [31:0]         O_AVS_READDATA,
  output logic                     O_AVS_WAITREQUEST,
  input  wire sahu_pkg::sahu_req_t I_REQ,
  input  wire sahu_pkg::sahu_dec_t I_DEC,
  input  wire logic [31:0]         I_PAGED_ADDR,
  input  wire logic                I_NMI,
  input  wire logic                I_OUTPUT_FLOAT_REQUEST,
  input  wire logic                I_MASKABLE_INTERRUPT_REQUEST,
  input  wire logic                I_INT_VALID,
  input  wire logic [7:0]          I_INT_VECTOR,
  input  wire logic [15:0]         I_STACK_POINTER,
  input  wire logic [31:0]         I_NEXT_INSTRUCTION_POINTER,
  output logic      [31:0]         O_PHYS_ADDR,
  output logic                     O_PHYS_VALID,
  output logic                     O_BUS_ENABLE,
  output logic                     O_BUS_LOCK,
  output logic                     O_OPSZ32,
  output sahu_pkg::sahu_fault_t    O_FAULT,
  output logic [19:0]              O_VECTOR_ADDR,
  output logic                     O_HALTED,
  output logic                     O_SHUTDOWN,
  output logic [31:0]              O_SAVED_INSTRUCTION_POINTER,
  output logic [15:0]              O_SAVED_CODE_SEGMENT
);
  import sahu_pkg::*;

  logic [2:0]  ctrl;
  logic [15:0] idt_limit;
  logic [31:0] seg_base;
  logic [7:0]  access_byte;
  logic [15:0] code_selector;
  logic [31:0] dt_base;
  logic        halted;
  logic        shutdown;
  logic        locked;
  logic        cmd_halt;
  logic        cmd_unlock;
  logic [1:0]  requestor_level;
  logic [1:0]  descriptor_level;
  logic [1:0]  current_level;
  logic [1:0]  effective_level;
  logic [12:0] dt_index;
  logic [31:0] dt_entry_addr;
  logic        pe;
  logic [19:0] real_addr;
  logic [32:0] last_byte;
  logic        real_overrun;
  logic        stack_wrap_odd;
  logic [31:0] prot_linear;
  logic        lock_legal;
  logic        lock_fault;
  logic [15:0] vec_hi;
  logic        vec_beyond;
  logic        gp_beyond;
  logic        wake_halt;
  logic        nmi_exit_ok;
  logic        wr_hit;
  logic [31:0] next_rdata;

  // mode bit and the accepted-write strobe shared by all register writes
  assign pe = ctrl[CTRL_PE];
  assign wr_hit = I_AVS_WRITE && !O_AVS_WAITREQUEST;

  // privilege level derivations and descriptor table indexing
  assign requestor_level  = code_selector[1:0];
  assign descriptor_level = access_byte[6:5];
  assign current_level    = code_selector[1:0];
  assign effective_level  = (requestor_level > descriptor_level) ? requestor_level : descriptor_level;
  assign dt_index         = code_selector[15:3];
  assign dt_entry_addr    = dt_base + {16'h0000, dt_index, 3'b000};

  // real mode address: segment << 4 plus offset, wraps in 20 bits
  assign real_addr = 20'({I_REQ.segment, 4'h0}) + 20'(I_REQ.offset[15:0]);
  assign last_byte = {1'b0, I_REQ.offset} + {30'h0, I_REQ.size_m1};
  // any byte past offset FFFFH is outside the 64-Kb segment
  assign real_overrun = (last_byte > {17'h0_0000, SEG_LAST});
  // odd stack pointer wrapping below zero on a push
  assign stack_wrap_odd = I_REQ.stack && I_STACK_POINTER[0] && (I_STACK_POINTER < 16'h0002);
  assign prot_linear = seg_base + I_REQ.offset;

  // lock legality, deliberately blind to current_level and io level
  always_comb begin
    case (I_DEC.lkcls)
      SAHU_LK_XCHG:    lock_legal = 1'b1;
      SAHU_LK_BITTEST,
      SAHU_LK_ALU,
      SAHU_LK_UNARY:   lock_legal = I_DEC.mem_dest;
      default:         lock_legal = 1'b0;
    endcase
  end
  assign lock_fault = I_DEC.valid && I_DEC.lock_prefix && (!lock_legal || I_DEC.rep_string);

  // real vector fetch needs 4 bytes inside the table limit
  assign vec_hi     = {6'h00, I_INT_VECTOR, 2'b11};
  assign vec_beyond = vec_hi > idt_limit;
  // an overrun raises vector 13, so shutdown depends on that entry, not on the pending interrupt
  assign gp_beyond  = {6'h00, FAULT_GP, 2'b11} > idt_limit;
  assign nmi_exit_ok = (idt_limit >= NMI_LIM_MIN) && (I_STACK_POINTER > NMI_SP_MIN);
  assign wake_halt = I_NMI || I_OUTPUT_FLOAT_REQUEST ||
                     (I_MASKABLE_INTERRUPT_REQUEST && ctrl[CTRL_IF]);

  // avalon slave: waitrequest idles high and drops for one cycle to accept a read or a write;
  // every access costs two cycles, traded for a pin that comes straight from a flop
  // and a read word that is already registered when the master takes it
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      O_AVS_WAITREQUEST <= !(O_AVS_WAITREQUEST && (I_AVS_READ || I_AVS_WRITE));
    end
  end

  // control register; protected mode off after reset
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl <= 3'b000;
    end else if (wr_hit && I_AVS_ADDRESS == OFF_CTRL && I_AVS_BYTEENABLE[0]) begin
      ctrl <= I_AVS_WRITEDATA[2:0];
    end
  end

  // table limit, descriptor base and access, selector, table base
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      idt_limit     <= IDTLIM_RST;
      seg_base      <= 32'h0000_0000;
      access_byte   <= 8'h00;
      code_selector <= RST_CS;
      dt_base       <= 32'h0000_0000;
    end else if (wr_hit) begin
      case (I_AVS_ADDRESS)
        OFF_IDTLIM:   idt_limit     <= I_AVS_WRITEDATA[15:0];
        OFF_SEGBASE:  seg_base      <= I_AVS_WRITEDATA;
        OFF_ACCESS:   access_byte   <= I_AVS_WRITEDATA[7:0];
        OFF_SELECTOR: code_selector <= I_AVS_WRITEDATA[15:0];
        OFF_DTBASE:   dt_base       <= I_AVS_WRITEDATA;
        default:      ;
      endcase
    end
  end

  // command strobes, one cycle long, only on an accepted write
  assign cmd_halt   = wr_hit && I_AVS_ADDRESS == OFF_CMD && I_AVS_WRITEDATA[0];
  assign cmd_unlock = wr_hit && I_AVS_ADDRESS == OFF_CMD && I_AVS_WRITEDATA[1];

  // halt state; a wake event wins over a halt issued the same cycle
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      halted <= 1'b0;
    end else if (wake_halt) begin
      halted <= 1'b0;
    end else if (cmd_halt || (I_DEC.valid && I_DEC.halt_instruction)) begin
      halted <= 1'b1;
    end
  end

  // shutdown: only nmi with room, or reset, gets out
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      shutdown <= 1'b0;
    end else if (!pe && ((I_INT_VALID && vec_beyond) ||
                         (I_REQ.valid && real_overrun && gp_beyond) ||
                         (I_REQ.valid && stack_wrap_odd))) begin
      shutdown <= 1'b1;
    end else if (I_NMI && nmi_exit_ok) begin
      shutdown <= 1'b0;
    end
  end

  // bus lock held across a permitted locked read-modify-write
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      locked <= 1'b0;
    end else if (I_DEC.valid && I_DEC.lock_prefix && !lock_fault) begin
      locked <= 1'b1;
    end else if (cmd_unlock) begin
      locked <= 1'b0;
    end
  end

  // address valid; bus cycles suppressed while halted or shut down, and on a real overrun
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PHYS_VALID <= 1'b0;
    end else begin
      O_PHYS_VALID <= I_REQ.valid && !halted && !shutdown && !(!pe && real_overrun);
    end
  end

  // address output, picked by mode and paging; only meaningful while valid is high
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PHYS_ADDR <= 32'h0000_0000;
    end else begin
      if (!pe) begin
        O_PHYS_ADDR <= {12'h000, real_addr};
      end else if (ctrl[CTRL_PG]) begin
        O_PHYS_ADDR <= {8'h00, I_PAGED_ADDR[23:0]};
      end else begin
        O_PHYS_ADDR <= {8'h00, prot_linear[23:0]};
      end
    end
  end

  // fault reporting; real mode only ever raises 6, 8 or 13
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FAULT <= '0;
    end else if (lock_fault) begin
      O_FAULT <= '{valid: 1'b1, vector: FAULT_UD};
    end else if (!pe && I_REQ.valid && real_overrun) begin
      O_FAULT <= '{valid: 1'b1, vector: FAULT_GP};
    end else if (!pe && I_INT_VALID && vec_beyond) begin
      O_FAULT <= '{valid: 1'b1, vector: FAULT_DF};
    end else begin
      O_FAULT <= '0;
    end
  end

  // real mode vector address, clipped into the reserved low table
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_VECTOR_ADDR <= 20'h0_0000;
    end else if (I_INT_VALID) begin
      O_VECTOR_ADDR <= {10'h000, I_INT_VECTOR, 2'b00} & VEC_TOP;
    end
  end

  // return pointer saved when nmi, a float request or an enabled interrupt wakes the halted core
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SAVED_INSTRUCTION_POINTER <= RST_IP;
      O_SAVED_CODE_SEGMENT        <= RST_CS;
    end else if (halted && wake_halt) begin
      O_SAVED_INSTRUCTION_POINTER <= I_NEXT_INSTRUCTION_POINTER;
      O_SAVED_CODE_SEGMENT        <= code_selector;
    end
  end

  // bus enable drops while halted or shut down, so no local cycle starts then
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_BUS_ENABLE <= 1'b0;
    end else begin
      O_BUS_ENABLE <= !halted && !shutdown;
    end
  end

  // lock pin follows the internal lock one cycle later
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_BUS_LOCK <= 1'b0;
    end else begin
      O_BUS_LOCK <= locked;
    end
  end

  // operand size: in real mode only a prefix widens it; protected mode is shown as wide
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_OPSZ32 <= 1'b0;
    end else begin
      O_OPSZ32 <= pe ? 1'b1 : (I_DEC.valid && I_DEC.size_ovr);
    end
  end

  // halt flag shown one cycle after the internal state
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_HALTED <= 1'b0;
    end else begin
      O_HALTED <= halted;
    end
  end

  // shutdown flag shown one cycle after the internal state
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SHUTDOWN <= 1'b0;
    end else begin
      O_SHUTDOWN <= shutdown;
    end
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (I_AVS_ADDRESS)
      OFF_CTRL:     next_rdata = {29'h0, ctrl};
      OFF_STATUS:   next_rdata = {27'h0, locked, O_OPSZ32, pe, shutdown, halted};
      OFF_IDTLIM:   next_rdata = {16'h0000, idt_limit};
      OFF_SEGBASE:  next_rdata = seg_base;
      OFF_ACCESS:   next_rdata = {24'h00_0000, access_byte};
      OFF_SELECTOR: next_rdata = {16'h0000, code_selector};
      OFF_LEVELS:   next_rdata = {24'h00_0000, effective_level, current_level, descriptor_level, requestor_level};
      OFF_DTBASE:   next_rdata = dt_base;
      OFF_DTADDR:   next_rdata = dt_entry_addr;
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, so it already stands at the edge where waitrequest is low
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_AVS_READ && O_AVS_WAITREQUEST) begin
      O_AVS_READDATA <= next_rdata;
    end
  end
endmodule : sahu_top
